// file: verilog/slr_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE1: shortcut register always reads back zero
// RULE2: 0x11/0x12 one converter, second stays powered
// RULE3: 0x21/0x22 two converters, one or two lanes
// RULE4: tail bits zero or 9-bit PN
// RULE5: pattern 0000 sends normal sample data
// RULE6: 0001 checkerboard, 0010 ones/zeros toggle
// RULE7: PN23, PN9, PN7, PN15 by code
// RULE8: 0101 repeats user word, 0110 once
// RULE9: software pairs RPAT with injection 01
// RULE10: software avoids reserved and undefined codes
// RULE11: alignment mode 01 normal, 11 continuous
// RULE12: software holds power-down while configuring
module slr_regs (
    // clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         rst,
    // serial control port pins
    input  wire logic                         spi_sclk,
    input  wire logic                         spi_csb_n,
    input  wire logic                         spi_sdi,
    output logic                              spi_sdo,
    output logic                              spi_sdo_oe,
    // converter samples in
    input  wire logic [slr_pkg::SAMP_W-1:0]   samp_a,
    input  wire logic [slr_pkg::SAMP_W-1:0]   samp_b,
    input  wire logic                         samp_valid,
    output logic                              samp_ready,
    // link words out
    output logic [slr_pkg::WORD_W-1:0]        link_data,
    output logic                              link_valid,
    input  wire logic                         link_ready,
    // configuration to the link and detector
    output slr_pkg::slr_cfg_t                 link_cfg,
    output logic [15:0]                       detect_dwell
);
    typedef struct packed {
        logic [2:0]  sclk_sy;   // sclk synchroniser plus history
        logic [1:0]  csb_sy;    // chip select synchroniser
        logic [1:0]  sdi_sy;    // data in synchroniser
        logic [4:0]  cnt;       // bits received in frame
        logic [22:0] shreg;     // received bits
        logic        is_read;   // current frame reads
        logic [7:0]  rd_shift;  // read data shifting out
        logic        sdo;       // serial data out
        logic [15:0] dwell;     // fast level detect dwell time
        logic        conv_two;  // two converters
        logic        lanes_two; // two lanes
        logic [7:0]  ctl1;      // link control one
        logic [7:0]  ctl2;      // link control two
        logic [7:0]  tst;       // link test control
        logic [22:0] prbs;      // pattern lfsr
        logic [8:0]  tail_pn;   // tail bit lfsr
        logic        alt;       // alternating pattern phase
        logic        chan_b;    // next word comes from converter b
        logic        user_sent; // single user word already sent
        logic [3:0]  last_tp;   // pattern code last cycle
    } slr_st_t;

    slr_st_t s_r;
    slr_st_t s_nxt;

    logic                      sclk_rise;   // synced rising edge
    logic                      sclk_fall;   // synced falling edge
    logic                      csb_act;     // frame active
    logic [23:0]               in_vec;      // bits including current one
    logic [12:0]               wr_addr;     // address at frame end
    logic [7:0]                wr_data;     // data at frame end
    logic [7:0]                rd_data;     // read mux result
    logic [slr_pkg::WORD_W-1:0] gen_word;   // generated word
    logic                      gen_valid;   // generated word offered
    logic                      fifo_ready;  // fifo accepts
    logic                      push;        // word enters fifo
    logic [slr_pkg::SAMP_W-1:0] samp_sel;   // selected converter
    logic [1:0]                tail_bits;   // spare bits
    logic                      pn_fb;       // selected prbs feedback
    logic [22:0]               pn_mask;     // selected prbs length mask

    assign sclk_rise = s_r.sclk_sy[1] && !s_r.sclk_sy[2];
    assign sclk_fall = !s_r.sclk_sy[1] && s_r.sclk_sy[2];
    assign csb_act   = !s_r.csb_sy[1];
    assign in_vec    = {s_r.shreg, s_r.sdi_sy[1]};
    assign wr_addr   = in_vec[20:8];
    assign wr_data   = in_vec[7:0];

    // register read mux, addressed by the header just received
    always_comb begin
        case (in_vec[slr_pkg::SPI_ADDR_W-1:0])
            slr_pkg::ADDR_DWELL_LO:  rd_data = s_r.dwell[7:0];
            slr_pkg::ADDR_DWELL_HI:  rd_data = s_r.dwell[15:8];
            slr_pkg::ADDR_SHORTCUT:  rd_data = slr_pkg::READ_ZERO; // [RULE1]
            slr_pkg::ADDR_LINK_CTL1: rd_data = s_r.ctl1;
            slr_pkg::ADDR_LINK_CTL2: rd_data = s_r.ctl2;
            slr_pkg::ADDR_LINK_TEST: rd_data = s_r.tst;
            default:                 rd_data = slr_pkg::READ_ZERO;
        endcase
    end

    // prbs length and feedback picked by the pattern code
    always_comb begin
        case (s_r.tst[3:0])
            slr_pkg::TP_PN7: begin // [RULE7]
                pn_fb   = s_r.prbs[slr_pkg::PN7_HI] ^
                          s_r.prbs[slr_pkg::PN7_TAP];
                pn_mask = 23'h00007f;
            end
            slr_pkg::TP_PN9: begin // [RULE7]
                pn_fb   = s_r.prbs[slr_pkg::PN9_HI] ^
                          s_r.prbs[slr_pkg::PN9_TAP];
                pn_mask = 23'h0001ff;
            end
            slr_pkg::TP_PN15: begin // [RULE7]
                pn_fb   = s_r.prbs[slr_pkg::PN15_HI] ^
                          s_r.prbs[slr_pkg::PN15_TAP];
                pn_mask = 23'h007fff;
            end
            default: begin // [RULE7]
                pn_fb   = s_r.prbs[slr_pkg::PN23_HI] ^
                          s_r.prbs[slr_pkg::PN23_TAP];
                pn_mask = 23'h7fffff;
            end
        endcase
    end

    // sample framing: spare bits below the 14-bit sample
    always_comb begin
        samp_sel = (s_r.conv_two && s_r.chan_b) ? samp_b : samp_a;
        // control bits are never framed here, so the spare bits are tail
        tail_bits = s_r.ctl1[slr_pkg::CTL1_TAIL_PN] ?
                    s_r.tail_pn[1:0] : 2'h0; // [RULE4]
    end

    // word generator; power-down and a pattern's reseed cycle push nothing
    always_comb begin
        gen_valid = 1'b1;
        case (s_r.tst[3:0])
            slr_pkg::TP_NORMAL: begin // [RULE5]
                gen_word  = {samp_sel, tail_bits};
                gen_valid = samp_valid;
            end
            slr_pkg::TP_CHECKER: begin // [RULE6]
                gen_word = s_r.alt ? slr_pkg::CHECKER_B : slr_pkg::CHECKER_A;
            end
            slr_pkg::TP_TOGGLE: begin // [RULE6]
                gen_word = s_r.alt ? slr_pkg::ALL_ZEROS : slr_pkg::ALL_ONES;
            end
            slr_pkg::TP_PN23, slr_pkg::TP_PN9,
            slr_pkg::TP_PN7, slr_pkg::TP_PN15: begin // [RULE7]
                gen_word = s_r.prbs[15:0];
            end
            slr_pkg::TP_USER_RP: begin // [RULE8]
                gen_word = slr_pkg::USER_WORD;
            end
            slr_pkg::TP_USER_1: begin // [RULE8]
                gen_word  = slr_pkg::USER_WORD;
                gen_valid = !s_r.user_sent;
            end
            slr_pkg::TP_RPAT: begin
                // injection point is not checked: pairing is software's job
                gen_word = s_r.prbs[15:0]; // [RULE9]
            end
            default: begin
                // reserved and unused codes send nothing
                gen_word  = slr_pkg::ALL_ZEROS; // [RULE10]
                gen_valid = 1'b0;
            end
        endcase
        if (s_r.ctl2[slr_pkg::CTL2_INVERT]) begin
            gen_word = ~gen_word;
        end
        if (s_r.ctl1[slr_pkg::CTL1_PWR_DOWN] ||
            (s_r.tst[3:0] != s_r.last_tp)) begin
            gen_valid = 1'b0; // [RULE12]
        end
    end
    assign push       = gen_valid && fifo_ready;
    assign samp_ready = fifo_ready &&
                        !s_r.ctl1[slr_pkg::CTL1_PWR_DOWN] &&
                        (s_r.tst[3:0] == s_r.last_tp) &&
                        (s_r.tst[3:0] == slr_pkg::TP_NORMAL);

    // next state: serial port, registers and pattern state
    always_comb begin
        s_nxt = s_r;
        s_nxt.sclk_sy = {s_r.sclk_sy[1:0], spi_sclk};
        s_nxt.csb_sy  = {s_r.csb_sy[0], spi_csb_n};
        s_nxt.sdi_sy  = {s_r.sdi_sy[0], spi_sdi};
        if (!csb_act) begin
            // deselect aborts any partial frame
            s_nxt.cnt     = '0;
            s_nxt.is_read = 1'b0;
        end else if (sclk_rise && s_r.cnt <= slr_pkg::SPI_FRAME_LAST) begin
            s_nxt.shreg = in_vec[22:0];
            s_nxt.cnt   = s_r.cnt + 5'h01;
            if (s_r.cnt == slr_pkg::SPI_HDR_LAST) begin
                s_nxt.is_read  = in_vec[slr_pkg::SPI_RD_BIT];
                s_nxt.rd_shift = rd_data;
            end
            if (s_r.cnt == slr_pkg::SPI_FRAME_LAST && !s_r.is_read) begin
                case (wr_addr)
                    slr_pkg::ADDR_DWELL_LO:  s_nxt.dwell[7:0]  = wr_data;
                    slr_pkg::ADDR_DWELL_HI:  s_nxt.dwell[15:8] = wr_data;
                    slr_pkg::ADDR_SHORTCUT: begin
                        // unknown codes leave the framing untouched
                        if (wr_data == slr_pkg::QC_M1_L1 ||
                            wr_data == slr_pkg::QC_M1_L2) begin
                            s_nxt.conv_two  = 1'b0; // [RULE2]
                            s_nxt.lanes_two = (wr_data == slr_pkg::QC_M1_L2);
                        end else if (wr_data == slr_pkg::QC_M2_L1 ||
                                     wr_data == slr_pkg::QC_M2_L2) begin
                            s_nxt.conv_two  = 1'b1; // [RULE3]
                            s_nxt.lanes_two = (wr_data == slr_pkg::QC_M2_L2);
                        end
                    end
                    slr_pkg::ADDR_LINK_CTL1:
                        s_nxt.ctl1 = wr_data & slr_pkg::CTL1_WR_MASK;
                    slr_pkg::ADDR_LINK_CTL2: s_nxt.ctl2 = wr_data;
                    slr_pkg::ADDR_LINK_TEST:
                        s_nxt.tst = wr_data & slr_pkg::TEST_WR_MASK;
                    default: ;
                endcase
            end
        end else if (sclk_fall && s_r.is_read &&
                     s_r.cnt >= slr_pkg::SPI_DATA_FIRST) begin
            // data changes on the falling edge, ready for the next rise
            s_nxt.sdo      = s_r.rd_shift[7];
            s_nxt.rd_shift = {s_r.rd_shift[6:0], 1'b0};
        end
        // pattern state advances only with accepted words
        s_nxt.last_tp = s_r.tst[3:0];
        if (s_r.tst[3:0] != s_r.last_tp) begin
            s_nxt.user_sent = 1'b0;
            s_nxt.prbs      = slr_pkg::PRBS_SEED;
        end else if (push) begin
            s_nxt.alt     = !s_r.alt;
            s_nxt.chan_b  = s_r.conv_two && !s_r.chan_b;
            s_nxt.prbs    = {s_r.prbs[21:0], pn_fb} & pn_mask;
            s_nxt.tail_pn = {s_r.tail_pn[7:0],
                             s_r.tail_pn[slr_pkg::PN9_HI] ^
                             s_r.tail_pn[slr_pkg::PN9_TAP]}; // [RULE4]
            if (s_r.tst[3:0] == slr_pkg::TP_USER_1) begin
                s_nxt.user_sent = 1'b1; // [RULE8]
            end
        end
    end
    // state register with synchronous reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_r           <= '0;
            s_r.csb_sy    <= 2'h3;
            s_r.dwell     <= {slr_pkg::RST_DWELL, slr_pkg::RST_DWELL};
            s_r.ctl1      <= slr_pkg::RST_LINK_CTL1; // [RULE11]
            s_r.ctl2      <= slr_pkg::RST_LINK_CTL2;
            s_r.tst       <= slr_pkg::RST_LINK_TEST;
            s_r.prbs      <= slr_pkg::PRBS_SEED;
            s_r.tail_pn   <= slr_pkg::TAIL_SEED;
        end else begin
            s_r <= s_nxt;
        end
    end
    // outputs
    assign spi_sdo    = s_r.sdo;
    assign spi_sdo_oe = csb_act && s_r.is_read &&
                        (s_r.cnt >= slr_pkg::SPI_DATA_FIRST);
    assign detect_dwell = s_r.dwell;

    always_comb begin
        link_cfg.conv_two     = s_r.conv_two;
        link_cfg.lanes_two    = s_r.lanes_two;
        link_cfg.conv_b_pd    = 1'b0; // [RULE2]
        link_cfg.link_pd      = s_r.ctl1[slr_pkg::CTL1_PWR_DOWN];
        link_cfg.ilas_mode    = s_r.ctl1[slr_pkg::CTL1_ILAS_LO +: 2];
        link_cfg.ilas_always  = (s_r.ctl1[slr_pkg::CTL1_ILAS_LO +: 2] ==
                                 slr_pkg::ILAS_ALWAYS); // [RULE11]
        link_cfg.inject_sel   = s_r.tst[slr_pkg::TEST_INJ_LO +: 2];
        link_cfg.pattern      = s_r.tst[3:0];
        link_cfg.test_samp_en = s_r.ctl1[slr_pkg::CTL1_TEST_SAMP];
    end

    // 16-word buffer between generator and link
    slr_fifo #(
        .WIDTH (slr_pkg::WORD_W),
        .DEPTH (slr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (gen_valid),
        .in_ready  (fifo_ready),
        .in_data   (gen_word),
        .out_valid (link_valid),
        .out_ready (link_ready),
        .out_data  (link_data)
    );
endmodule
`default_nettype wire

// file: common/slr_pkg.sv
package slr_pkg;

    // serial port framing: read flag, two ignored bits, 13-bit address, data
    localparam int         SPI_ADDR_W     = 13;
    localparam logic [4:0] SPI_HDR_LAST   = 5'h0f;  // count at last header bit
    localparam logic [4:0] SPI_FRAME_LAST = 5'h17;  // count at last data bit
    localparam logic [4:0] SPI_DATA_FIRST = 5'h10;  // first data bit count
    localparam int         SPI_RD_BIT     = 15;     // read flag in header

    // register addresses
    localparam logic [12:0] ADDR_DWELL_LO   = 13'h004b;
    localparam logic [12:0] ADDR_DWELL_HI   = 13'h004c;
    localparam logic [12:0] ADDR_SHORTCUT   = 13'h005e;
    localparam logic [12:0] ADDR_LINK_CTL1  = 13'h005f;
    localparam logic [12:0] ADDR_LINK_CTL2  = 13'h0060;
    localparam logic [12:0] ADDR_LINK_TEST  = 13'h0061;
    localparam logic [12:0] ADDR_LINK_RSVD  = 13'h0062;

    // reset values
    localparam logic [7:0] RST_DWELL     = 8'h00;
    localparam logic [7:0] RST_LINK_CTL1 = 8'h14;
    localparam logic [7:0] RST_LINK_CTL2 = 8'h00;
    localparam logic [7:0] RST_LINK_TEST = 8'h00;
    localparam logic [7:0] READ_ZERO     = 8'h00;

    // shortcut codes
    localparam logic [7:0] QC_M1_L1 = 8'h11;
    localparam logic [7:0] QC_M1_L2 = 8'h12;
    localparam logic [7:0] QC_M2_L1 = 8'h21;
    localparam logic [7:0] QC_M2_L2 = 8'h22;

    // link control one field positions
    localparam int CTL1_TAIL_PN   = 6;
    localparam int CTL1_TEST_SAMP = 5;
    localparam int CTL1_ILAS_LO   = 2;
    localparam int CTL1_PWR_DOWN  = 0;
    localparam logic [7:0] CTL1_WR_MASK = 8'h7f;
    // link control two
    localparam int CTL2_INVERT    = 1;
    // link test control
    localparam int TEST_INJ_LO    = 4;
    localparam logic [7:0] TEST_WR_MASK = 8'h3f;

    // lane alignment modes
    localparam logic [1:0] ILAS_NORMAL = 2'h1;
    localparam logic [1:0] ILAS_ALWAYS = 2'h3;

    // test pattern codes
    typedef enum logic [3:0] {
        TP_NORMAL  = 4'h0,
        TP_CHECKER = 4'h1,
        TP_TOGGLE  = 4'h2,
        TP_PN23    = 4'h3,
        TP_PN9     = 4'h4,
        TP_USER_RP = 4'h5,
        TP_USER_1  = 4'h6,
        TP_RSVD    = 4'h7,
        TP_RPAT    = 4'h8,
        TP_PN7     = 4'hc,
        TP_PN15    = 4'hd
    } slr_tp_t;

    // pattern words
    localparam logic [15:0] CHECKER_A   = 16'haaaa;
    localparam logic [15:0] CHECKER_B   = 16'h5555;
    localparam logic [15:0] ALL_ONES    = 16'hffff;
    localparam logic [15:0] ALL_ZEROS   = 16'h0000;
    localparam logic [15:0] USER_WORD   = 16'h1234;
    localparam logic [22:0] PRBS_SEED   = 23'h7fffff;
    localparam logic [8:0]  TAIL_SEED   = 9'h1ff;

    // prbs feedback taps as (length, tap) bit indices
    localparam int PN7_HI  = 6;
    localparam int PN7_TAP = 5;
    localparam int PN9_HI  = 8;
    localparam int PN9_TAP = 4;
    localparam int PN15_HI = 14;
    localparam int PN15_TAP = 13;
    localparam int PN23_HI = 22;
    localparam int PN23_TAP = 17;

    localparam int SAMP_W = 14;
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 16;

    // configuration seen by the link
    typedef struct packed {
        logic       conv_two;       // two converters framed
        logic       lanes_two;      // two lanes in use
        logic       conv_b_pd;      // second converter power-down
        logic       link_pd;        // link powered down
        logic [1:0] ilas_mode;      // lane alignment mode
        logic       ilas_always;    // alignment runs continuously
        logic [1:0] inject_sel;     // test injection point
        logic [3:0] pattern;        // test pattern code
        logic       test_samp_en;   // test sample enabled
    } slr_cfg_t;

endpackage

// file: verilog/slr_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module slr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;   // storage words
        logic [AW:0]                 wptr;  // write pointer with wrap bit
        logic [AW:0]                 rptr;  // read pointer with wrap bit
    } slr_fifo_st_t;

    slr_fifo_st_t s_r;
    slr_fifo_st_t s_nxt;

    logic full;
    logic empty;

    // the extra pointer bit tells full from empty without a counter
    assign empty     = (s_r.wptr == s_r.rptr);
    assign full      = (s_r.wptr[AW] != s_r.rptr[AW]) &&
                       (s_r.wptr[AW-1:0] == s_r.rptr[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = s_r.mem[s_r.rptr[AW-1:0]];

    // pointer and storage update
    always_comb begin
        s_nxt = s_r;
        if (in_valid && !full) begin
            s_nxt.mem[s_r.wptr[AW-1:0]] = in_data;
            s_nxt.wptr = s_r.wptr + 1'b1;
        end
        if (out_ready && !empty) begin
            s_nxt.rptr = s_r.rptr + 1'b1;
        end
    end

    // state register; storage needs no reset, only the pointers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_r.mem  <= s_nxt.mem;
            s_r.wptr <= '0;
            s_r.rptr <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

`default_nettype wire

// file: test/slr_link_sink.sv
`timescale 1ns/1ps
`default_nettype none

module slr_link_sink (
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    // link words from the block
    input  wire logic [slr_pkg::WORD_W-1:0] link_data,
    input  wire logic                       link_valid,
    output logic                            link_ready,
    // bench control: hold off to play a slow receiver
    input  wire logic                       stall
);
    logic [15:0] got[$];  // words taken, oldest first

    // ready only while not stalled; a slow receiver just drops ready
    assign link_ready = !stall;

    // a word moves only on an edge with valid and ready both high
    always @(posedge core_clk) begin
        if (!rst && link_valid && link_ready) begin
            got.push_back(link_data);
        end
    end
endmodule

`default_nettype wire

// file: test/slr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module slr_regs_asserts (
    // clock and reset
    input wire logic              core_clk,
    input wire logic              rst,
    // serial select
    input wire logic              spi_csb_n,
    // data path
    input wire logic              samp_valid,
    input wire logic              samp_ready,
    input wire logic [15:0]       link_data,
    input wire logic              link_valid,
    input wire logic              link_ready,
    // link configuration
    input wire slr_pkg::slr_cfg_t link_cfg
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    ilas_flag_a: assert property (
        link_cfg.ilas_always == (link_cfg.ilas_mode == 2'h3))
        else $error("alignment flag disagrees with mode");
    ilas_reset_a: assert property (
        $fell(rst) |-> link_cfg.ilas_mode == 2'h1 && !link_cfg.link_pd)
        else $error("alignment mode not normal after reset");
    conv_b_pwr_a: assert property (
        !link_cfg.conv_b_pd)
        else $error("second converter powered down");
    // a write only lands inside a frame, so an idle select freezes it
    cfg_quiet_a: assert property (
        spi_csb_n [*6] |-> $stable(link_cfg))
        else $error("configuration moved without a frame");
    test_block_a: assert property (
        link_cfg.pattern != 4'h0 |-> !samp_ready)
        else $error("samples taken during a test pattern");
    pd_block_a: assert property (
        link_cfg.link_pd |-> !samp_ready)
        else $error("samples taken while link is down");
    push_valid_a: assert property (
        samp_valid && samp_ready |=> link_valid)
        else $error("pushed sample did not show");
    stall_hold_a: assert property (
        link_valid && !link_ready |=> link_valid && $stable(link_data))
        else $error("word changed while stalled");
    rsvd_quiet_a: assert property (
        link_cfg.pattern == 4'h7 && !link_valid |=> !link_valid)
        else $error("reserved pattern produced a word");
endmodule

bind slr_regs slr_regs_asserts chk_i (
    .core_clk(core_clk), .rst(rst), .spi_csb_n(spi_csb_n),
    .samp_valid(samp_valid), .samp_ready(samp_ready),
    .link_data(link_data), .link_valid(link_valid),
    .link_ready(link_ready), .link_cfg(link_cfg)
);

`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic              core_clk   = 1'b0;
    logic              rst        = 1'b1;
    logic              spi_sclk   = 1'b0;  // stands low between frames
    logic              spi_csb_n  = 1'b1;
    logic              spi_sdi    = 1'b0;
    logic [13:0]       samp_a     = 14'h0000;
    logic [13:0]       samp_b     = 14'h0000;
    logic              samp_valid = 1'b0;
    logic              stall      = 1'b0;
    logic              spi_sdo, spi_sdo_oe, samp_ready, link_valid;
    logic              link_ready;
    logic [15:0]       link_data, detect_dwell;
    slr_pkg::slr_cfg_t link_cfg;
    int                num_errors = 0;
    int                checks     = 0;

    always #10 core_clk = ~core_clk;

    slr_regs DUT (.core_clk(core_clk), .rst(rst), .spi_sclk(spi_sclk),
        .spi_csb_n(spi_csb_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
        .spi_sdo_oe(spi_sdo_oe), .samp_a(samp_a), .samp_b(samp_b),
        .samp_valid(samp_valid), .samp_ready(samp_ready),
        .link_data(link_data), .link_valid(link_valid),
        .link_ready(link_ready), .link_cfg(link_cfg),
        .detect_dwell(detect_dwell));
    slr_link_sink sink (.core_clk(core_clk), .rst(rst),
        .link_data(link_data), .link_valid(link_valid),
        .link_ready(link_ready), .stall(stall));

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one frame; sclk levels of 4 to 6 cycles outlast the synchroniser
    task automatic spi(input logic [23:0] f, output logic [7:0] r);
        spi_csb_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi_sdi <= f[i];
            tick(6);
            if (i < 8) r[i] = spi_sdo_oe ? spi_sdo : 1'bx;
            spi_sclk <= 1'b1;
            tick(4);
            spi_sclk <= 1'b0;
        end
        tick(6);
        spi_csb_n <= 1'b1;
        spi_sdi   <= ~spi_sdi;  // stale data must not look meaningful
        tick(6);
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] r;
        spi({3'b000, a, d}, r);
    endtask

    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        logic [7:0] r;
        spi({3'b100, a, 8'h00}, r);
        chk({8'h00, r}, {8'h00, e});
    endtask

    function automatic logic [15:0] cv();
        return {13'h0000, link_cfg.conv_two, link_cfg.lanes_two,
                link_cfg.conv_b_pd};
    endfunction

    // samples count up from zero, one offered per cycle
    task automatic push(input int n, input logic hold);
        sink.got.delete();
        stall      <= hold;
        samp_valid <= 1'b1;
        for (int i = 0; i < n; i++) begin
            samp_a <= 14'(i);
            tick(1);
        end
        samp_valid <= 1'b0;
    endtask

    task automatic t_regs();
        rd(13'h005f, 8'h14);
        rd(13'h0061, 8'h00);
        chk({14'h0000, link_cfg.ilas_mode}, 16'h0001);
        wr(13'h004b, 8'ha5);
        wr(13'h004c, 8'h3c);
        chk(detect_dwell, 16'h3ca5);
        wr(13'h0062, 8'hff);
        rd(13'h0062, 8'h00);
        rd(13'h0100, 8'h00);
        wr(13'h005f, 8'hff);
        rd(13'h005f, 8'h7f);
        chk({15'h0000, link_cfg.ilas_always}, 16'h0001);
        wr(13'h005f, 8'h14);
    endtask

    task automatic t_shortcut();
        logic [7:0] codes[4] = '{8'h11, 8'h12, 8'h21, 8'h22};
        wr(13'h005f, 8'h15);
        foreach (codes[i]) begin
            wr(13'h005e, codes[i]);
            rd(13'h005e, 8'h00);
            chk(cv(), {13'h0000, codes[i][5], codes[i][1], 1'b0});
        end
        wr(13'h005e, 8'h33);
        chk(cv(), 16'h0006);
        wr(13'h005e, 8'h11);
        chk(cv(), 16'h0000);
        wr(13'h005f, 8'h14);
    endtask

    task automatic t_data();
        logic [1:0] t;
        push(20, 1'b1);
        chk({15'h0000, samp_ready}, 16'h0000);
        stall <= 1'b0;
        tick(24);
        chk(16'(sink.got.size()), 16'h0010);
        foreach (sink.got[k]) chk(sink.got[k], {14'(k), 2'b00});
        wr(13'h005f, 8'h54);
        push(8, 1'b0);
        tick(4);
        t = 2'b00;
        foreach (sink.got[k]) begin
            chk({2'b00, sink.got[k][15:2]}, 16'(k));
            t |= sink.got[k][1:0];
        end
        chk({15'h0000, |t}, 16'h0001);
        wr(13'h005f, 8'h14);
    endtask

    // run one pattern, return it to normal and let the fifo drain
    task automatic pat(input logic [7:0] v, output logic [15:0] w0,
                       output logic [15:0] w1, output logic [15:0] n);
        sink.got.delete();
        wr(13'h0061, v);
        tick(30);
        wr(13'h0061, 8'h00);
        tick(20);
        n  = 16'(sink.got.size());
        w0 = sink.got[0];
        w1 = sink.got[1];
    endtask

    task automatic t_patterns();
        logic [7:0]  pn[5] = '{8'h03, 8'h04, 8'h0c, 8'h0d, 8'h18};
        logic [15:0] w0, w1, n;
        pat(8'h01, w0, w1, n);
        chk(w0 ^ w1, 16'hffff);
        chk({1'b0, w0[15:1] ^ w0[14:0]}, 16'h7fff);
        pat(8'h02, w0, w1, n);
        chk(w0 ^ w1, 16'hffff);
        chk({1'b0, w0[15:1] ^ w0[14:0]}, 16'h0000);
        foreach (pn[i]) begin
            pat(pn[i], w0, w1, n);
            chk({15'h0000, w0 != w1}, 16'h0001);
        end
        pat(8'h05, w0, w1, n);
        chk(w0, 16'h1234);
        chk(w1, 16'h1234);
        wr(13'h0060, 8'h02);
        pat(8'h05, w0, w1, n);
        chk(w0, 16'hedcb);
        wr(13'h0060, 8'h00);
        pat(8'h06, w0, w1, n);
        chk(n, 16'h0001);
        pat(8'h07, w0, w1, n);
        chk(n, 16'h0000);
    endtask

    task automatic end_of_test();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // the full run needs about 13000 cycles
    initial begin
        tick(60000);
        num_errors++;
        end_of_test();
    end

    initial begin
        tick(8);
        rst <= 1'b0;
        tick(4);
        t_regs();
        t_shortcut();
        t_data();
        t_patterns();
        end_of_test();
    end
endmodule

`default_nettype wire
